// [pkg/clksw_regs.vh]
// register offsets, fields, source codes, unlock keys and timing counts of the clock switch block
`ifndef CLKSW_REGS_VH
`define CLKSW_REGS_VH
`define OSC_CTRL_ADDR      4'h0
`define OSC_UNLOCK_ADDR    4'h4
`define PWR_CTRL_ADDR      4'h8
`define SRC_CUR_LSB        12
`define SRC_NEW_LSB        8
`define BIT_CFG_LOCK       7
`define BIT_PLL_LOCK       5
`define BIT_CLK_FAIL       3
`define BIT_SEC_EN         1
`define BIT_SWITCH_REQ     0
`define SRC_FRC            3'h0
`define SRC_FRC_PLL        3'h1
`define SRC_PRI            3'h2
`define SRC_PRI_PLL        3'h3
`define SRC_SEC            3'h4
`define SRC_LOW_POWER_RC_OSC           3'h5
`define SRC_FRC_DIV16      3'h6
`define SRC_FRC_DIVN       3'h7
`define UNLOCK_KEY1        8'h46
`define UNLOCK_KEY2        8'h57
`define SETTLE_CYCLES      4'ha
`define IDLE_WAKE_CYCLES   2'h2
`define PWR_SLEEP_BIT      0
`define PWR_IDLE_BIT       1
`endif

// [src/clock_switch_failsafe_powersave.v]
// clock source switching, fail-safe fallback and sleep/idle control
`include "clksw_regs.vh"
module clock_switch_failsafe_powersave #(
  parameter WDT_EN_DEFAULT = 1'b0
) (
  input  wire        mclk_i,
  input  wire        reset_n_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        switch_monitor_disable_cfg_i,
  input  wire        switch_lock_cfg_i,
  input  wire [2:0]  initial_source_cfg_i,
  input  wire [1:0]  primary_submode_cfg_i,
  input  wire        watchdog_enable_i,
  input  wire        osc_startup_timer_done_i,
  input  wire        pll_locked_i,
  input  wire        new_clock_tick_i,
  input  wire        osc_fail_i,
  input  wire        power_save_instr_i,
  input  wire        power_save_idle_i,
  input  wire        wake_irq_i,
  input  wire        wdt_timeout_i,
  output reg  [2:0]  sys_source_o,
  output wire [1:0]  primary_submode_o,
  output wire        fast_rc_osc_en_o,
  output wire        primary_osc_en_o,
  output wire        secondary_osc_en_o,
  output wire        low_power_rc_osc_en_o,
  output wire        pll_en_o,
  output wire        sys_clk_run_o,
  output wire        periph_clk_run_o,
  output wire        cpu_clk_run_o,
  output wire        failsafe_monitor_active_o,
  output reg         clock_fail_trap_o,
  output reg         wdt_clear_o
);
  // one-hot states
  localparam [4:0] ST_RUN    = 5'h01;
  localparam [4:0] ST_READY  = 5'h02;
  localparam [4:0] ST_SETTLE = 5'h04;
  localparam [4:0] ST_SLEEP  = 5'h08;
  localparam [4:0] ST_IDLE   = 5'h10;

  function uses_pll;
    input [2:0] s;
    begin
      uses_pll = (s == `SRC_FRC_PLL) || (s == `SRC_PRI_PLL);
    end
  endfunction
  function uses_frc;
    input [2:0] s;
    begin
      uses_frc = (s == `SRC_FRC) || (s == `SRC_FRC_PLL) || (s == `SRC_FRC_DIV16) ||
                 (s == `SRC_FRC_DIVN);
    end
  endfunction

  // primary crystal in either plain or PLL form
  function is_primary;
    input [2:0] s;
    begin
      is_primary = (s == `SRC_PRI) || (s == `SRC_PRI_PLL);
    end
  endfunction

  // fallback keeps the PLL so the multiplier still applies to fast rc
  function [2:0] fallback_src;
    input [2:0] s;
    begin
      fallback_src = uses_pll(s) ? `SRC_FRC_PLL : `SRC_FRC;
    end
  endfunction

  reg  [4:0] state_q;
  reg  [2:0] current_source_stat_q;
  reg  [2:0] new_source_sel_q;
  reg        switch_request_q;
  reg        clock_fail_flag_q;
  reg        pll_lock_flag_q;
  reg        clock_config_lock_q;
  reg        secondary_osc_enable_q;
  reg  [1:0] unlock_q;
  reg  [3:0] settle_q;
  reg  [1:0] wake_q;
  reg        cfg_loaded_q;
  reg        wdt_en_q;
  reg  [2:0] fail_sync_q;
  reg  [2:0] tick_sync_q;
  reg  [2:0] ost_sync_q;
  reg  [2:0] lock_sync_q;
  reg        tick_lvl_q;

  wire sw_en     = ~switch_monitor_disable_cfg_i;
  wire cfg_block = clock_config_lock_q & switch_lock_cfg_i;
  wire wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr        = wb_req & wb_we_i;
  wire wr_ctrl   = wr & (wb_adr_i == `OSC_CTRL_ADDR);
  wire wr_key    = wr & (wb_adr_i == `OSC_UNLOCK_ADDR) & wb_sel_i[0];
  wire wr_pwr    = wr & (wb_adr_i == `PWR_CTRL_ADDR) & wb_sel_i[0];
  wire unlocked  = (unlock_q == 2'h2);
  wire wr_hi     = wr_ctrl & wb_sel_i[1] & unlocked;
  wire wr_lo     = wr_ctrl & wb_sel_i[0] & unlocked;

  // async inputs: count once second and third stage agree
  wire fail_seen = fail_sync_q[1] & fail_sync_q[2];
  // new-clock edge counts once stages two and three agree on high
  // a stand-in tick narrower than two clocks is lost
  wire tick_rise = tick_sync_q[1] & tick_sync_q[2] & ~tick_lvl_q;
  wire ost_done  = ost_sync_q[1] & ost_sync_q[2];
  wire pll_lock  = lock_sync_q[1] & lock_sync_q[2];
  wire mon_on    = sw_en & (state_q != ST_SLEEP);
  wire fail_evt  = mon_on & fail_seen & ~clock_fail_flag_q;
  wire wake_evt  = wake_irq_i | wdt_timeout_i;
  wire xtal_new  = is_primary(new_source_sel_q) || (new_source_sel_q == `SRC_SEC);

  // readiness: crystal waits for start-up timer, PLL for lock
  wire ost_ok    = ~xtal_new | ost_done;
  wire lock_ok   = ~uses_pll(new_source_sel_q) | pll_lock;
  wire new_ready = ost_ok & lock_ok;

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fail_sync_q <= 3'h0;
      tick_sync_q <= 3'h0;
      ost_sync_q  <= 3'h0;
      lock_sync_q <= 3'h0;
      tick_lvl_q  <= 1'b0;
    end else begin
      // filtered tick level only moves when the late stages agree
      if (tick_sync_q[1] == tick_sync_q[2])
        tick_lvl_q <= tick_sync_q[2];
      fail_sync_q <= {fail_sync_q[1:0], osc_fail_i};
      tick_sync_q <= {tick_sync_q[1:0], new_clock_tick_i};
      ost_sync_q  <= {ost_sync_q[1:0], osc_startup_timer_done_i};
      lock_sync_q <= {lock_sync_q[1:0], pll_locked_i};
    end
  end

  // unlock key sequence; any other write breaks it
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      unlock_q <= 2'h0;
    end else if (wr_key && wb_dat_i[7:0] == `UNLOCK_KEY1) begin
      unlock_q <= 2'h1;
    end else if (wr_key && unlock_q == 2'h1 && wb_dat_i[7:0] == `UNLOCK_KEY2) begin
      unlock_q <= 2'h2;
    end else if (wr) begin
      unlock_q <= 2'h0;
    end
  end

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q                <= ST_RUN;
      current_source_stat_q  <= `SRC_FRC;
      new_source_sel_q       <= `SRC_FRC;
      switch_request_q       <= 1'b0;
      clock_fail_flag_q      <= 1'b0;
      pll_lock_flag_q        <= 1'b0;
      clock_config_lock_q    <= 1'b0;
      secondary_osc_enable_q <= 1'b0;
      settle_q               <= 4'h0;
      wake_q                 <= 2'h0;
      cfg_loaded_q           <= 1'b0;
      wdt_en_q               <= 1'b0;
      sys_source_o           <= `SRC_FRC;
      clock_fail_trap_o      <= 1'b0;
      wdt_clear_o            <= 1'b0;
    end else begin
      clock_fail_trap_o <= 1'b0;
      wdt_clear_o       <= 1'b0;
      wdt_en_q          <= watchdog_enable_i | WDT_EN_DEFAULT;
      if (pll_lock && uses_pll(sys_source_o))
        pll_lock_flag_q <= 1'b1;
      // strap capture after reset release
      if (!cfg_loaded_q) begin
        cfg_loaded_q          <= 1'b1;
        current_source_stat_q <= initial_source_cfg_i;
        new_source_sel_q      <= initial_source_cfg_i;
        sys_source_o          <= initial_source_cfg_i;
      end else if (!sw_en) begin
        current_source_stat_q <= initial_source_cfg_i;
        sys_source_o          <= initial_source_cfg_i;
        switch_request_q      <= 1'b0;
      end
      if (wr_hi && !cfg_block && sw_en)
        new_source_sel_q <= wb_dat_i[`SRC_NEW_LSB +: 3];
      if (wr_lo) begin
        if (!cfg_block)
          clock_config_lock_q <= wb_dat_i[`BIT_CFG_LOCK];
        secondary_osc_enable_q <= wb_dat_i[`BIT_SEC_EN];
        // software may only clear the fail flag
        if (!wb_dat_i[`BIT_CLK_FAIL])
          clock_fail_flag_q <= 1'b0;
      end
      case (state_q)
        ST_RUN: begin
          if (fail_evt) begin
            clock_fail_trap_o     <= 1'b1;
            clock_fail_flag_q     <= 1'b1;
            switch_request_q      <= 1'b0;
            current_source_stat_q <= fallback_src(sys_source_o);
            sys_source_o          <= fallback_src(sys_source_o);
          end else if (cfg_loaded_q && power_save_instr_i) begin
            // watchdog clear on entry
            // live input: the registered copy lags by one cycle
            wdt_clear_o <= watchdog_enable_i | WDT_EN_DEFAULT;
            state_q     <= power_save_idle_i ? ST_IDLE : ST_SLEEP;
          end else if (wr_lo && sw_en && !cfg_block && wb_dat_i[`BIT_SWITCH_REQ]) begin
            if (new_source_sel_q == current_source_stat_q) begin
              switch_request_q <= 1'b0;
            end else begin
              switch_request_q  <= 1'b1;
              // flags cleared, set of fail wins
              pll_lock_flag_q   <= 1'b0;
              clock_fail_flag_q <= 1'b0;
              state_q           <= ST_READY;
            end
          end
        end
        ST_READY: begin
          settle_q <= 4'h0;
          if (fail_evt) begin
            state_q <= ST_RUN;
          end else if (new_ready) begin
            state_q <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (tick_rise)
            settle_q <= settle_q + 4'h1;
          if (fail_evt) begin
            state_q <= ST_RUN;
          end else if (settle_q == `SETTLE_CYCLES) begin
            switch_request_q      <= 1'b0;
            current_source_stat_q <= new_source_sel_q;
            sys_source_o          <= new_source_sel_q;
            state_q               <= ST_RUN;
          end
        end
        ST_SLEEP: begin
          // wake events; source kept
          // source code untouched, so wake resumes on it
          if (wake_evt)
            state_q <= ST_RUN;
        end
        ST_IDLE: begin
          // delayed CPU restart
          // wake may drop early; the countdown runs on regardless
          if (wake_q != 2'h0) begin
            wake_q <= wake_q - 2'h1;
            if (wake_q == 2'h1)
              state_q <= ST_RUN;
          end else if (wake_evt) begin
            wake_q <= `IDLE_WAKE_CYCLES;
          end
        end
        default: state_q <= ST_RUN;
      endcase
      // fail event while switching still traps
      if (fail_evt && state_q != ST_RUN) begin
        clock_fail_trap_o     <= 1'b1;
        clock_fail_flag_q     <= 1'b1;
        switch_request_q      <= 1'b0;
        current_source_stat_q <= fallback_src(sys_source_o);
        sys_source_o          <= fallback_src(sys_source_o);
      end
    end
  end

  wire sleeping  = (state_q == ST_SLEEP);
  wire switching = (state_q == ST_READY) || (state_q == ST_SETTLE);
  wire [2:0] tgt = new_source_sel_q;

  // fast rc, primary, secondary and PLL run for the live source and, while switching, the target; low power rc only for the live source
  wire frc_need = uses_frc(sys_source_o) | (switching & uses_frc(tgt));
  wire pri_need = is_primary(sys_source_o) | (switching & is_primary(tgt));
  wire sec_need = (sys_source_o == `SRC_SEC) | (switching & (tgt == `SRC_SEC));
  wire pll_need = uses_pll(sys_source_o) | (switching & uses_pll(tgt));
  wire low_power_rc_osc_src = (sys_source_o == `SRC_LOW_POWER_RC_OSC);

  // sleep gates all but a watchdog-held low power rc and an enabled secondary; old source off after switch unless enable bit, watchdog or monitor holds it
  assign fast_rc_osc_en_o   = ~sleeping & frc_need;
  assign primary_osc_en_o   = ~sleeping & pri_need;
  // secondary kept alive by its enable bit, even across sleep
  assign secondary_osc_en_o = secondary_osc_enable_q | (~sleeping & sec_need);
  assign pll_en_o           = ~sleeping & pll_need;
  assign low_power_rc_osc_en_o = wdt_en_q | (sw_en & ~sleeping) | (~sleeping & low_power_rc_osc_src);
  assign primary_submode_o  = primary_submode_cfg_i;
  assign sys_clk_run_o      = ~sleeping;
  assign periph_clk_run_o   = ~sleeping;
  assign cpu_clk_run_o      = (state_q != ST_SLEEP) && (state_q != ST_IDLE);
  assign failsafe_monitor_active_o = mon_on;


  // one wait state; unmapped reads return zero
  // read data is cleared every cycle so it only stands with ack
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == `OSC_CTRL_ADDR) begin
          wb_dat_o[`SRC_CUR_LSB +: 3] <= current_source_stat_q;
          wb_dat_o[`SRC_NEW_LSB +: 3] <= new_source_sel_q;
          wb_dat_o[`BIT_CFG_LOCK]     <= clock_config_lock_q;
          wb_dat_o[`BIT_PLL_LOCK]     <= pll_lock_flag_q;
          wb_dat_o[`BIT_CLK_FAIL]     <= clock_fail_flag_q;
          wb_dat_o[`BIT_SEC_EN]       <= secondary_osc_enable_q;
          wb_dat_o[`BIT_SWITCH_REQ]   <= switch_request_q;
        end else if (wb_adr_i == `PWR_CTRL_ADDR) begin
          wb_dat_o[`PWR_SLEEP_BIT] <= sleeping;
          wb_dat_o[`PWR_IDLE_BIT]  <= (state_q == ST_IDLE);
        end
      end
    end
  end
  // wr_pwr reserved for future use is unread; writes there are accepted and ignored
  wire unused_pwr = wr_pwr;
endmodule // clock_switch_failsafe_powersave

// [tb/clksw_properties.sv]
// port-level assertions for the clock switch block
`include "clksw_regs.vh"
module clksw_properties (
  input wire       mclk_i,
  input wire       reset_n_i,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_ack_o,
  input wire       switch_monitor_disable_cfg_i,
  input wire       watchdog_enable_i,
  input wire       power_save_instr_i,
  input wire [1:0] primary_submode_cfg_i,
  input wire [1:0] primary_submode_o,
  input wire [2:0] sys_source_o,
  input wire       low_power_rc_osc_en_o,
  input wire       sys_clk_run_o,
  input wire       periph_clk_run_o,
  input wire       cpu_clk_run_o,
  input wire       failsafe_monitor_active_o,
  input wire       clock_fail_trap_o,
  input wire       wdt_clear_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_MON_OFF: assert property (switch_monitor_disable_cfg_i |-> !failsafe_monitor_active_o)
    else $error("monitor active while disabled");
  AST_SUBMODE: assert property (primary_submode_o == primary_submode_cfg_i)
    else $error("primary submode differs from strap");
  AST_LOW_POWER_RC_OSC_MON: assert property (failsafe_monitor_active_o |-> low_power_rc_osc_en_o)
    else $error("low power rc off while monitor active");
  AST_SLEEP_CLK: assert property (!sys_clk_run_o |-> !periph_clk_run_o && !cpu_clk_run_o)
    else $error("clocks running in sleep");
  AST_SLEEP_MON: assert property (!sys_clk_run_o |-> !failsafe_monitor_active_o)
    else $error("monitor active in sleep");
  AST_TRAP_SRC: assert property (clock_fail_trap_o |->
    ##[0:2] (sys_source_o == `SRC_FRC || sys_source_o == `SRC_FRC_PLL))
    else $error("no fallback to fast rc after trap");
  AST_TRAP_PULSE: assert property (clock_fail_trap_o |=> !clock_fail_trap_o)
    else $error("trap longer than one cycle");
  AST_WDT_CLR: assert property (power_save_instr_i && watchdog_enable_i && cpu_clk_run_o
    |-> ##[1:2] wdt_clear_o)
    else $error("watchdog not cleared on power save entry");
  COV_TRAP: cover property (clock_fail_trap_o);
  COV_SLEEP: cover property ($fell(sys_clk_run_o));
  COV_IDLE: cover property ($fell(cpu_clk_run_o) && sys_clk_run_o);
endmodule // clksw_properties
bind clock_switch_failsafe_powersave clksw_properties u_props (.*);

// [tb/tb_top.sv]
// self-checking bench for the clock switch block
`include "clksw_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, q;
  wire  [31:0] rdat;
  wire         ack;
  logic        dis_cfg = 1'b1, osc_startup_timer = 1'b0, tick = 1'b0, fail = 1'b0, wdt_en = 1'b0;
  logic        ps = 1'b0, ps_idle = 1'b0, irq = 1'b0, wdt_to = 1'b0;
  logic [2:0]  init_src = `SRC_PRI;
  wire  [2:0]  src;
  wire  [1:0]  submode;
  wire         frc_en, pri_en, low_power_rc_osc_en, sys_run, per_run, cpu_run, mon, trap;
  wire         sec_en, pll_en, wclr;
  int          num_errors = 0, n_compared = 0, n;
  always #10 mclk_i = ~mclk_i;
  clock_switch_failsafe_powersave DUT (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .switch_monitor_disable_cfg_i(dis_cfg), .switch_lock_cfg_i(1'b0),
    .initial_source_cfg_i(init_src), .primary_submode_cfg_i(2'h1),
    .watchdog_enable_i(wdt_en), .osc_startup_timer_done_i(osc_startup_timer), .pll_locked_i(1'b0),
    .new_clock_tick_i(tick), .osc_fail_i(fail), .power_save_instr_i(ps),
    .power_save_idle_i(ps_idle), .wake_irq_i(irq), .wdt_timeout_i(wdt_to),
    .sys_source_o(src), .primary_submode_o(submode), .fast_rc_osc_en_o(frc_en),
    .primary_osc_en_o(pri_en), .secondary_osc_en_o(sec_en), .low_power_rc_osc_en_o(low_power_rc_osc_en),
    .pll_en_o(pll_en), .sys_clk_run_o(sys_run), .periph_clk_run_o(per_run),
    .cpu_clk_run_o(cpu_run), .failsafe_monitor_active_o(mon),
    .clock_fail_trap_o(trap), .wdt_clear_o(wclr));
  task automatic close_out;
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic cycle: hold until ack sampled high
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s,
                     input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    i = 0;
    do begin
      @(posedge mclk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      num_errors++;
      close_out();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 4'hf, 32'h0);
  endtask
  task automatic unlock;
    bus(1'b1, `OSC_UNLOCK_ADDR, 4'h1, {24'h0, `UNLOCK_KEY1});
    bus(1'b1, `OSC_UNLOCK_ADDR, 4'h1, {24'h0, `UNLOCK_KEY2});
  endtask
  task automatic set_new(input logic [2:0] s, input logic ul);
    if (ul)
      unlock();
    bus(1'b1, `OSC_CTRL_ADDR, 4'h2, {21'h0, s, 8'h0});
  endtask
  task automatic request;
    unlock();
    bus(1'b1, `OSC_CTRL_ADDR, 4'h1, 32'h1);
  endtask
  // slow stand-in clock, wide enough for the input synchroniser
  task automatic ticks(input int k);
    repeat (k) begin
      tick <= 1'b1;
      repeat (3) @(posedge mclk_i);
      tick <= 1'b0;
      repeat (3) @(posedge mclk_i);
    end
  endtask
  task automatic pwr(input logic idle);
    ps_idle <= idle;
    ps <= 1'b1;
    @(posedge mclk_i);
    ps <= 1'b0;
    #1;
    chk({31'h0, wclr}, {31'h0, wdt_en});
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic do_reset(input logic d, input logic [2:0] s);
    reset_n_i <= 1'b0;
    dis_cfg <= d;
    init_src <= s;
    repeat (16) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
  endtask
  initial begin
    do_reset(1'b1, `SRC_PRI);
    rd(`OSC_CTRL_ADDR);
    chk(q & 32'h7001, 32'h2000);
    set_new(`SRC_SEC, 1'b1);
    request();
    repeat (30) @(posedge mclk_i);
    rd(`OSC_CTRL_ADDR);
    chk(q & 32'h7001, 32'h2000);
    chk({29'h0, src}, {29'h0, `SRC_PRI});
    chk({30'h0, submode}, 32'h1);
    do_reset(1'b0, `SRC_FRC);
    set_new(`SRC_PRI, 1'b0);
    rd(`OSC_CTRL_ADDR);
    chk(q & 32'h0700, 32'h0);
    request();
    repeat (8) @(posedge mclk_i);
    rd(`OSC_CTRL_ADDR);
    chk(q & 32'h7001, 32'h0);
    set_new(`SRC_PRI, 1'b1);
    request();
    ticks(12);
    chk({29'h0, src}, {29'h0, `SRC_FRC});
    osc_startup_timer <= 1'b1;
    repeat (5) @(posedge mclk_i);
    ticks(9);
    chk({29'h0, src}, {29'h0, `SRC_FRC});
    ticks(1);
    repeat (6) @(posedge mclk_i);
    chk({29'h0, src}, {29'h0, `SRC_PRI});
    rd(`OSC_CTRL_ADDR);
    chk(q & 32'h7701, 32'h2200);
    chk({28'h0, pll_en, sec_en, pri_en, frc_en}, 32'h2);
    wdt_en <= 1'b1;
    pwr(1'b0);
    chk({27'h0, sys_run, per_run, cpu_run, mon, low_power_rc_osc_en}, 32'h1);
    irq <= 1'b1;
    repeat (4) @(posedge mclk_i);
    irq <= 1'b0;
    chk({28'h0, sys_run, src}, {28'h0, 1'b1, `SRC_PRI});
    pwr(1'b1);
    chk({29'h0, sys_run, per_run, cpu_run}, 32'h6);
    wdt_to <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
    end while (cpu_run !== 1'b1 && n < 20);
    wdt_to <= 1'b0;
    @(posedge mclk_i);
    chk({31'h0, (n >= 3 && n <= 5)}, 32'h1);
    fail <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (trap !== 1'b1 && n < 20);
    chk({31'h0, trap}, 32'h1);
    repeat (3) @(posedge mclk_i);
    fail <= 1'b0;
    chk({29'h0, src}, {29'h0, `SRC_FRC});
    rd(`OSC_CTRL_ADDR);
    chk(q & 32'h7008, 32'h0008);
    rd(4'hc);
    chk(q, 32'h0);
    close_out();
  end
  initial begin
    #2000000;
    num_errors++;
    close_out();
  end
endmodule // tb_top
